// ---- rtl/port_event_stats_defines.svh ----
// Register offsets, field positions, reset values and page numbers.
// Included by the register bank and its tally submodule.
`ifndef PORT_EVENT_STATS_DEFINES_SVH
`define PORT_EVENT_STATS_DEFINES_SVH

`define NUM_PORTS 13
`define PAGE_CONFIG 2'h0
`define PAGE_FLAGS 2'h1
`define PAGE_TALLY_LOW 2'h2
`define PAGE_TALLY_HIGH 2'h3
`define ADDR_PORT_FIRST 5'h11
`define ADDR_PORT_LAST 5'h1D
`define ADDR_TALLY_MASK 5'h13
`define ADDR_RECORD_MASK 5'h14
`define ADDR_CHIP_NUMBER 5'h17
`define ADDR_COMPRESS_COUNT 5'h18
`define ADDR_GAP_THRESHOLD 5'h1F
`define TALLY_MASK_CLEAR_AFTER_READ 0
`define TALLY_MASK_SATURATE_AT_MAX 1
`define TALLY_MASK_WRITABLE 8'h3B
`define CHIP_ID_MSB 7
`define CHIP_ID_LSB 2
`define CHIP_ID_FIELD_MASK 8'hFC
`define RESET_CHIP_NUMBER 8'h00
`define RESET_COMPRESS_COUNT 8'h00
`define RESET_GAP_THRESHOLD 8'h00
`define RESET_TALLY_MASK 8'h00
`define RESET_RECORD_MASK 8'h00
`define TALLY_MAX 16'hFFFF

`endif

// ---- rtl/port_event_stats_pkg.sv ----
// Types shared by the register bank and the tally submodule.
// Assumes the defines header is compiled alongside.
package port_event_stats_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] tally_t;
  typedef logic [3:0] port_idx_t;
endpackage

// ---- rtl/port_tally.sv ----
// One port's 16-bit event tally with clear-after-read and saturation.
// Assumes increment and read-clear requests are synchronous to mclk.
`timescale 1ns/1ps
`include "port_event_stats_defines.svh"
module port_tally (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Controls
  input wire logic count_event,
  input wire logic read_clear,
  input wire logic saturate_at_max,
  // State
  output port_event_stats_pkg::tally_t event_tally
);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      event_tally <= 16'h0000;
    end else if (read_clear) begin
      event_tally <= 16'h0000;
    end else if (count_event) begin
      if (!(saturate_at_max && event_tally == `TALLY_MAX)) begin
        event_tally <= event_tally + 16'h0001;
      end
    end
  end
endmodule

// ---- rtl/port_event_stats_regs.sv ----
// Hub-management statistics and configuration registers of a repeater.
// Assumes event pulses are one-cycle strobes synchronous to mclk and the
// processor read and write strobes are one-cycle pulses.
//
// Contract
// - Chip number register holds a six-bit identifier in bits 7..2.
// - Stored identifier is driven to the management-bus logic.
// - Compress count tells management logic how many data bytes to pass.
// - Minimum management-bus gap is threshold register plus one bit times.
// - One event-flag register per port at page one, 11H to 1DH.
// - Reading a flag register returns the flags then clears them.
// - Flag register is read-only with the eight documented event bits.
// - Each port has a 16-bit tally incremented by enabled events.
// - Tally mask bits select clear-after-read and saturation.
// - Reading either tally byte copies all 16 bits to a holding register.
// - Other byte of the same tally next is read from holding register.
// - Holding reloads on a different tally or same byte reread.
// - Tally bytes sit on pages two and three.
// - Clear-after-read set makes a tally read reset that tally.
// - Saturate set stops a tally at FFFF instead of wrapping.
// - A flag is recorded only if its record mask bit is one.
`timescale 1ns/1ps
`include "port_event_stats_defines.svh"
module port_event_stats_regs (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Processor port
  input wire logic [1:0] page_sel,
  input wire logic [4:0] reg_addr,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic [7:0] write_data,
  output port_event_stats_pkg::byte_t read_data,
  // Port events, one bit per port
  input wire logic [12:0] ev_babble_timeout,
  input wire logic [12:0] ev_elastic_buffer_fault,
  input wire logic [12:0] ev_lock_loss,
  input wire logic [12:0] ev_missing_delimiter,
  input wire logic [12:0] ev_short_burst,
  input wire logic [12:0] ev_late_collision,
  input wire logic [12:0] ev_partition,
  input wire logic [12:0] ev_link_failure,
  // Tally increment requests, already qualified by the count enables
  input wire logic [12:0] tally_event,
  // Management interface configuration
  output logic [5:0] chip_id,
  output port_event_stats_pkg::byte_t compress_count,
  output logic [8:0] min_gap_bits
);
  localparam int NP = `NUM_PORTS;

  port_event_stats_pkg::byte_t chip_number_reg;
  port_event_stats_pkg::byte_t compress_count_reg;
  port_event_stats_pkg::byte_t gap_threshold_reg;
  port_event_stats_pkg::byte_t tally_mask_reg;
  port_event_stats_pkg::byte_t record_mask_reg;
  port_event_stats_pkg::byte_t flags_reg [NP];
  port_event_stats_pkg::tally_t holding_reg;
  port_event_stats_pkg::port_idx_t held_port_reg;
  logic held_high_reg;
  logic held_valid_reg;
  port_event_stats_pkg::tally_t tally [NP];
  logic [12:0] tally_clear;

  // Returns true for an in-range per-port address.
  function automatic logic is_port_addr(input logic [4:0] a);
    return (a >= `ADDR_PORT_FIRST) && (a <= `ADDR_PORT_LAST);
  endfunction

  // Maps a per-port address to a port index.
  function automatic port_event_stats_pkg::port_idx_t port_of(
    input logic [4:0] a);
    logic [4:0] d;
    d = a - `ADDR_PORT_FIRST;
    return d[3:0];
  endfunction

  logic cfg_wr;
  logic flag_rd;
  logic tally_rd;
  logic tally_hi;
  logic from_holding;
  port_event_stats_pkg::port_idx_t sel_port;

  assign cfg_wr = write_strobe && page_sel == `PAGE_CONFIG;
  assign flag_rd = read_strobe && page_sel == `PAGE_FLAGS &&
                   is_port_addr(reg_addr);
  assign tally_rd = read_strobe && is_port_addr(reg_addr) &&
                    (page_sel == `PAGE_TALLY_LOW ||
                     page_sel == `PAGE_TALLY_HIGH);
  assign tally_hi = page_sel == `PAGE_TALLY_HIGH;
  assign sel_port = port_of(reg_addr);
  assign from_holding = held_valid_reg && held_port_reg == sel_port &&
                        held_high_reg != tally_hi;

  // Configuration registers.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      chip_number_reg <= `RESET_CHIP_NUMBER;
      compress_count_reg <= `RESET_COMPRESS_COUNT;
      gap_threshold_reg <= `RESET_GAP_THRESHOLD;
      tally_mask_reg <= `RESET_TALLY_MASK;
      record_mask_reg <= `RESET_RECORD_MASK;
    end else if (cfg_wr) begin
      case (reg_addr)
        `ADDR_CHIP_NUMBER: chip_number_reg <= write_data & `CHIP_ID_FIELD_MASK;
        `ADDR_COMPRESS_COUNT: compress_count_reg <= write_data;
        `ADDR_GAP_THRESHOLD: gap_threshold_reg <= write_data;
        `ADDR_TALLY_MASK: tally_mask_reg <= write_data & `TALLY_MASK_WRITABLE;
        `ADDR_RECORD_MASK: record_mask_reg <= write_data;
        default: ;
      endcase
    end
  end

  assign chip_id = chip_number_reg[`CHIP_ID_MSB:`CHIP_ID_LSB];
  assign compress_count = compress_count_reg;
  assign min_gap_bits = {1'b0, gap_threshold_reg} + 9'h001;

  // Sticky flags; a new event in the read cycle survives the clear.
  for (genvar p = 0; p < NP; p++) begin : g_flags
    port_event_stats_pkg::byte_t ev;
    assign ev = {ev_link_failure[p], ev_partition[p], ev_late_collision[p],
                 ev_short_burst[p], ev_missing_delimiter[p], ev_lock_loss[p],
                 ev_elastic_buffer_fault[p], ev_babble_timeout[p]};
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        flags_reg[p] <= 8'h00;
      end else begin
        if (flag_rd && sel_port == 4'(p)) begin
          flags_reg[p] <= ev & record_mask_reg;
        end else begin
          flags_reg[p] <= flags_reg[p] | (ev & record_mask_reg);
        end
      end
    end
    assign tally_clear[p] = tally_rd && !from_holding && sel_port == 4'(p) &&
                            tally_mask_reg[`TALLY_MASK_CLEAR_AFTER_READ];
    port_tally u_tally (
      .mclk(mclk),
      .resetn(resetn),
      .count_event(tally_event[p]),
      .read_clear(tally_clear[p]),
      .saturate_at_max(tally_mask_reg[`TALLY_MASK_SATURATE_AT_MAX]),
      .event_tally(tally[p])
    );
  end

  // Coherent holding register for 16-bit tallies.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      holding_reg <= 16'h0000;
      held_port_reg <= 4'h0;
      held_high_reg <= 1'b0;
      held_valid_reg <= 1'b0;
    end else if (tally_rd) begin
      if (from_holding) begin
        // Pair completed; the next read reloads.
        held_valid_reg <= 1'b0;
      end else begin
        holding_reg <= tally[sel_port];
        held_port_reg <= sel_port;
        held_high_reg <= tally_hi;
        held_valid_reg <= 1'b1;
      end
    end
  end

  // Read data, registered one cycle after the strobe.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      read_data <= 8'h00;
    end else if (read_strobe) begin
      read_data <= 8'h00;
      case (page_sel)
        `PAGE_CONFIG: begin
          case (reg_addr)
            `ADDR_CHIP_NUMBER: read_data <= chip_number_reg;
            `ADDR_COMPRESS_COUNT: read_data <= compress_count_reg;
            `ADDR_GAP_THRESHOLD: read_data <= gap_threshold_reg;
            `ADDR_TALLY_MASK: read_data <= tally_mask_reg;
            `ADDR_RECORD_MASK: read_data <= record_mask_reg;
            default: read_data <= 8'h00;
          endcase
        end
        `PAGE_FLAGS: begin
          if (is_port_addr(reg_addr)) begin
            read_data <= flags_reg[sel_port];
          end
        end
        default: begin
          if (is_port_addr(reg_addr)) begin
            if (from_holding) begin
              read_data <= tally_hi ? holding_reg[15:8] : holding_reg[7:0];
            end else begin
              read_data <= tally_hi ? tally[sel_port][15:8]
                                    : tally[sel_port][7:0];
            end
          end
        end
      endcase
    end
  end
endmodule

// ---- verif/port_event_stats_monitor.sv ----
// Port checker for the register bank.
// Assumes one mclk domain with active-low asynchronous resetn.
`timescale 1ns/1ps
module port_event_stats_monitor (
  // Clock, reset and processor port
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [1:0] page_sel,
  input wire logic [4:0] reg_addr,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic [7:0] write_data,
  input wire port_event_stats_pkg::byte_t read_data,
  // Events and configuration
  input wire logic [12:0] ev_babble_timeout,
  input wire logic [5:0] chip_id,
  input wire port_event_stats_pkg::byte_t compress_count,
  input wire logic [8:0] min_gap_bits
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire logic w0 = write_strobe && page_sel == 2'h0;
  wire logic r0 = read_strobe && page_sel == 2'h0;
  wire logic rf = read_strobe && page_sel == 2'h1 && reg_addr == 5'h11;
  wire logic e0 = ev_babble_timeout[0];
  property p_chip; w0 && reg_addr == 5'h17 |=>
    chip_id == $past(write_data[7:2]); endproperty
  a_chip: assert property (p_chip) else $error("chip id wrong");
  property p_comp; w0 && reg_addr == 5'h18 |=>
    compress_count == $past(write_data); endproperty
  a_comp: assert property (p_comp) else $error("count wrong");
  property p_gap; w0 && reg_addr == 5'h1F |=>
    min_gap_bits == {1'b0, $past(write_data)} + 9'h001; endproperty
  a_gap: assert property (p_gap) else $error("gap wrong");
  property p_gap_hold; !write_strobe |=> $stable(min_gap_bits); endproperty
  a_gap_hold: assert property (p_gap_hold) else $error("gap moved");
  property p_resv; r0 && reg_addr == 5'h17 |=> read_data[1:0] == 2'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved set");
  property p_clear; rf && !e0 ##1 !e0 ##1 rf && !e0 |=> !read_data[0];
  endproperty
  a_clear: assert property (p_clear) else $error("flag kept");
  property p_page; write_strobe && page_sel != 2'h0 |=> $stable(chip_id)
    && $stable(compress_count); endproperty
  a_page: assert property (p_page) else $error("page write took");
  property p_mask; r0 && reg_addr == 5'h13 |=> (read_data & 8'hC4) == 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("mask bits set");
endmodule
bind port_event_stats_regs port_event_stats_monitor mon (.mclk(mclk),
  .resetn(resetn), .page_sel(page_sel), .reg_addr(reg_addr),
  .read_strobe(read_strobe), .write_strobe(write_strobe),
  .write_data(write_data), .read_data(read_data),
  .ev_babble_timeout(ev_babble_timeout), .chip_id(chip_id),
  .compress_count(compress_count), .min_gap_bits(min_gap_bits));

// ---- verif/cpu_model.sv ----
// Processor model with one-cycle read and write requests.
// Assumes the register bank answers a read at the next edge.
`timescale 1ns/1ps
module cpu_model (
  input wire logic mclk,
  output logic [1:0] page_sel,
  output logic [4:0] reg_addr,
  output logic read_strobe,
  output logic write_strobe,
  output logic [7:0] write_data,
  input wire port_event_stats_pkg::byte_t read_data
);
  initial begin
    page_sel = 2'h0;
    reg_addr = 5'h00;
    read_strobe = 1'b0;
    write_strobe = 1'b0;
    write_data = 8'h00;
  end
  task automatic wr(input logic [1:0] p, input logic [4:0] a,
                    input logic [7:0] d);
    @(posedge mclk);
    page_sel <= p;
    reg_addr <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge mclk);
    write_strobe <= 1'b0;
    // Released data is inverted so a stale value is never relied on.
    write_data <= ~d;
    #1;
  endtask
  task automatic rd(input logic [1:0] p, input logic [4:0] a,
                    output port_event_stats_pkg::byte_t d);
    @(posedge mclk);
    page_sel <= p;
    reg_addr <= a;
    read_strobe <= 1'b1;
    @(posedge mclk);
    read_strobe <= 1'b0;
    #1;
    d = read_data;
  endtask
endmodule

// ---- verif/port_event_stats_regs_tb.sv ----
// Self-checking bench for the register bank.
// Assumes the processor model drives the register port.
`timescale 1ns/1ps
module port_event_stats_regs_tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [12:0] ev [8];
  logic [12:0] tally_ev = 13'h0000;
  wire logic [1:0] pg;
  wire logic [4:0] ad;
  wire logic rs, ws;
  wire logic [7:0] wd;
  wire port_event_stats_pkg::byte_t rdat, cc;
  wire logic [5:0] cid;
  wire logic [8:0] gap;
  port_event_stats_pkg::byte_t rdv;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  always #5 mclk = ~mclk;
  cpu_model cpu (.mclk(mclk), .page_sel(pg), .reg_addr(ad), .read_strobe(rs),
    .write_strobe(ws), .write_data(wd), .read_data(rdat));
  port_event_stats_regs uut (.mclk(mclk), .resetn(resetn), .page_sel(pg),
    .reg_addr(ad), .read_strobe(rs), .write_strobe(ws), .write_data(wd),
    .read_data(rdat), .ev_babble_timeout(ev[0]),
    .ev_elastic_buffer_fault(ev[1]), .ev_lock_loss(ev[2]),
    .ev_missing_delimiter(ev[3]), .ev_short_burst(ev[4]),
    .ev_late_collision(ev[5]), .ev_partition(ev[6]),
    .ev_link_failure(ev[7]), .tally_event(tally_ev), .chip_id(cid),
    .compress_count(cc), .min_gap_bits(gap));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [1:0] p, input logic [4:0] a,
                    input logic [7:0] e);
    cpu.rd(p, a, rdv);
    chk({8'h00, rdv}, {8'h00, e});
  endtask
  // Index 8 selects the tally input; held high for n events.
  task automatic pulse(input int k, input int pt, input int n);
    @(posedge mclk);
    if (k < 8) ev[k][pt] <= 1'b1;
    else tally_ev[pt] <= 1'b1;
    repeat (n) @(posedge mclk);
    ev <= '{default: 13'h0000};
    tally_ev <= 13'h0000;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    ev = '{default: 13'h0000};
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    rc(2'h0, 5'h17, 8'h00);
    rc(2'h0, 5'h18, 8'h00);
    rc(2'h0, 5'h1F, 8'h00);
    chk({7'h00, gap}, 16'h0001);
    cpu.wr(2'h0, 5'h17, 8'hFF);
    rc(2'h0, 5'h17, 8'hFC);
    chk({10'h000, cid}, 16'h003F);
    cpu.wr(2'h1, 5'h17, 8'h00);
    chk({10'h000, cid}, 16'h003F);
    cpu.wr(2'h0, 5'h18, 8'hFF);
    chk({8'h00, cc}, 16'h00FF);
    cpu.wr(2'h0, 5'h1F, 8'h1F);
    chk({7'h00, gap}, 16'h0020);
    cpu.wr(2'h0, 5'h1F, 8'hFF);
    chk({7'h00, gap}, 16'h0100);
    rc(2'h0, 5'h00, 8'h00);
    cpu.wr(2'h0, 5'h13, 8'hFF);
    rc(2'h0, 5'h13, 8'h3B);
    cpu.wr(2'h0, 5'h13, 8'h00);
    $display("config test done");
    cpu.wr(2'h0, 5'h14, 8'h7F);
    for (int k = 0; k < 8; k++) begin
      pulse(k, 0, 1);
      rc(2'h1, 5'h11, (8'h01 << k) & 8'h7F);
      rc(2'h1, 5'h11, 8'h00);
    end
    pulse(0, 12, 1);
    rc(2'h1, 5'h12, 8'h00);
    rc(2'h1, 5'h1D, 8'h01);
    $display("flag test done");
    pulse(8, 0, 255);
    rc(2'h2, 5'h11, 8'hFF);
    pulse(8, 0, 1);
    rc(2'h3, 5'h11, 8'h00);
    rc(2'h3, 5'h11, 8'h01);
    cpu.wr(2'h0, 5'h13, 8'h01);
    pulse(8, 1, 5);
    rc(2'h2, 5'h12, 8'h05);
    rc(2'h2, 5'h12, 8'h00);
    cpu.wr(2'h0, 5'h13, 8'h02);
    pulse(8, 2, 65537);
    rc(2'h2, 5'h13, 8'hFF);
    rc(2'h3, 5'h13, 8'hFF);
    $display("tally test done");
    end_of_test();
  end
endmodule
